// ---- core/plck_pkg.sv ----
// Constants and types for the PLL lock and sleep clock gating block
//=====================================
// Behaviour
// - Crystal select translated to PLL settings
// - Translation readable, VCO within one percent
// - PLL off after reset; output divided by 16
// - Normal and power-down PLL modes
// - Relock on crystal change or power-up
// - PLL unusable during relock
// - Lock counter on main osc, load 0x1200
// - Crystal above 0x0f loads 0x2400
// - No PLL sysclk until counter expires
// - Stay on oscillator until lock, then switch
// - Lock raw flag and maskable interrupt
// - Monitor main osc band when enabled
// - Failure sets cause, switches to internal osc
// - Internal reset 32 periods, then NMI
// - Per-peripheral gating run, sleep, deep-sleep
// - Sleep stops core clock
// - Sleep uses sleep gates with auto gating
// - Deep-sleep source main osc or internal
// - Deep-sleep PLL off, divisor override if PLL was on at entry, restore
// - Extended config select picks extended fields
// - Divisor equals field plus one
package plck_pkg;
   //=====================================
   // Counts and reset values
   localparam logic [13:0] PLCK_LOCK_SHORT = 14'h1200;
   localparam logic [13:0] PLCK_LOCK_LONG = 14'h2400;
   localparam logic [4:0] PLCK_CRYSTAL_SELECT_LONG_MAX = 5'h0F;
   localparam logic [5:0] PLCK_POR_PERIODS = 6'h20;
   localparam logic [4:0] PLCK_CRYSTAL_SELECT_RESET = 5'h0B;
   localparam logic [6:0] PLCK_DIV_RESET = 7'h0F;
   localparam int PLCK_VCO_MHZ = 400;
   localparam int PLCK_VCO_PREDIV = 2;
   localparam int PLCK_DIV_W = 7;
   //=====================================
   // Mode enumerations
   typedef enum logic [1:0] {
      PLCK_RUN = 2'b00,
      PLCK_SLEEP = 2'b01,
      PLCK_DEEP = 2'b11
   } plck_mode_t;
   typedef enum logic [1:0] {
      PLCK_SRC_MAIN = 2'b00,
      PLCK_SRC_INT = 2'b01,
      PLCK_SRC_PLL = 2'b11
   } plck_src_t;
endpackage

// ---- core/plck_lock_cnt.sv ----
// Relock down counter on the main oscillator side
module plck_lock_cnt
   import plck_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic long_i,
   output logic busy_o,
   output logic done_o
);
   logic [13:0] cnt_reg;
   logic busy_reg;
   logic done_reg;
   //=====================================
   // Down counter
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_reg <= 14'h0000;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (ce_i) begin
         done_reg <= 1'b0;
         if (start_i) begin
            cnt_reg <= long_i ? PLCK_LOCK_LONG : PLCK_LOCK_SHORT;
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 14'h0001;
            if (cnt_reg == 14'h0001) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
         end
      end
   end
   assign busy_o = busy_reg;
   assign done_o = done_reg;
   load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && start_i && !long_i |=> cnt_reg == PLCK_LOCK_SHORT) else $error("lock load wrong");
   load_long_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && start_i && long_i |=> cnt_reg == PLCK_LOCK_LONG) else $error("long load wrong");
endmodule

// ---- core/plck_top.sv ----
// Clock control: PLL lock timing, oscillator check and sleep gating
module plck_top
   import plck_pkg::*;
#(
   parameter int NPER = 32,
   parameter int POR_PERIODS = int'(PLCK_POR_PERIODS)
)(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic [4:0] crystal_select_i,
   input wire logic crystal_wr_i,
   input wire logic pll_pwrdn_i,
   input wire logic bypass_i,
   input wire logic [3:0] sysclk_divisor_i,
   input wire logic auto_gate_i,
   input wire logic [1:0] osc_src_i,
   input wire logic ext_config_select_i,
   input wire logic ext_pll_pwrdn_i,
   input wire logic ext_bypass_i,
   input wire logic [5:0] ext_sysclk_divisor_i,
   input wire logic [1:0] ext_osc_src_i,
   input wire logic osc_check_enable_i,
   input wire logic main_osc_bad_i,
   input wire logic int_osc_tick_i,
   input wire logic int_osc_dis_i,
   input wire logic pll_lock_mask_i,
   input wire logic wfi_i,
   input wire logic deep_sleep_en_i,
   input wire logic wake_irq_i,
   input wire logic [1:0] deepsleep_clock_cfg_i,
   input wire logic [5:0] deepsleep_div_override_i,
   input wire logic [NPER-1:0] run_gating_regs_i,
   input wire logic [NPER-1:0] sleep_gating_regs_i,
   input wire logic [NPER-1:0] deepsleep_gating_regs_i,
   output logic [13:0] pll_translation_reg_o,
   output logic pll_lock_raw_flag_o,
   output logic pll_lock_irq_o,
   output logic pll_enable_o,
   output logic [1:0] sysclk_src_o,
   output logic [6:0] sysclk_div_o,
   output logic main_osc_en_o,
   output logic int_osc_en_o,
   output logic osc_fail_cause_o,
   output logic int_por_o,
   output logic nmi_o,
   output logic core_clk_en_o,
   output logic [NPER-1:0] periph_clk_en_o
);
   //=====================================
   // Input synchronisers for pin-side inputs
   logic bad_s1_reg, bad_s2_reg, tick_s1_reg, tick_s2_reg, tick_d_reg;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         bad_s1_reg <= 1'b0;
         bad_s2_reg <= 1'b0;
         tick_s1_reg <= 1'b0;
         tick_s2_reg <= 1'b0;
         tick_d_reg <= 1'b0;
      end else if (ce_i) begin
         bad_s1_reg <= main_osc_bad_i;
         bad_s2_reg <= bad_s1_reg;
         tick_s1_reg <= int_osc_tick_i;
         tick_s2_reg <= tick_s1_reg;
         tick_d_reg <= tick_s2_reg;
      end
   end
   wire tick_edge = tick_s2_reg & ~tick_d_reg;

   //=====================================
   // Field selection and translation
   function automatic logic [13:0] xlate(input logic [4:0] x);
      xlate = {4'h0, 5'h0C + x, x};
   endfunction
   wire sel_pwrdn = ext_config_select_i ? ext_pll_pwrdn_i : pll_pwrdn_i;
   wire sel_bypass = ext_config_select_i ? ext_bypass_i : bypass_i;
   wire [1:0] sel_src = ext_config_select_i ? ext_osc_src_i : osc_src_i;
   wire [5:0] sel_div_field = ext_config_select_i ? ext_sysclk_divisor_i : {2'b00, sysclk_divisor_i};
   wire [6:0] run_div = {1'b0, sel_div_field} + 7'h01;

   //=====================================
   // Relock detection
   logic [4:0] crystal_select_reg;
   logic pwrdn_d_reg;
   logic flag_reg, irq_reg;
   logic [13:0] xlate_reg;
   logic deep_pll_reg;
   wire crystal_select_change = crystal_wr_i && (crystal_select_i != crystal_select_reg);
   wire pll_pwrdn_eff = sel_pwrdn | deep_pll_reg;
   wire powerup = pwrdn_d_reg && !pll_pwrdn_eff;
   wire relock_start = crystal_select_change | powerup;
   wire lock_busy, lock_done;
   plck_lock_cnt u_cnt (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .start_i(relock_start),
      .long_i((crystal_select_change ? crystal_select_i : crystal_select_reg) > PLCK_CRYSTAL_SELECT_LONG_MAX),
      .busy_o(lock_busy),
      .done_o(lock_done)
   );
   wire pll_usable = !pll_pwrdn_eff && !lock_busy && !relock_start && flag_reg;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         crystal_select_reg <= PLCK_CRYSTAL_SELECT_RESET;
         xlate_reg <= xlate(PLCK_CRYSTAL_SELECT_RESET);
         pwrdn_d_reg <= 1'b1;
         flag_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else if (ce_i) begin
         if (crystal_wr_i) begin
            crystal_select_reg <= crystal_select_i;
            xlate_reg <= xlate(crystal_select_i);
         end
         pwrdn_d_reg <= pll_pwrdn_eff;
         if (lock_done) flag_reg <= 1'b1;
         else if (relock_start) flag_reg <= 1'b0;
         irq_reg <= pll_lock_mask_i && (lock_done || (flag_reg && !relock_start));
      end
   end

   //=====================================
   // Oscillator failure sequence
   logic fail_reg, por_reg, nmi_reg;
   logic [5:0] por_cnt_reg;
   wire fail_det = osc_check_enable_i && bad_s2_reg && !fail_reg;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fail_reg <= 1'b0;
         por_reg <= 1'b0;
         nmi_reg <= 1'b0;
         por_cnt_reg <= 6'h00;
      end else if (ce_i) begin
         nmi_reg <= 1'b0;
         if (fail_det) begin
            fail_reg <= 1'b1;
            por_reg <= 1'b1;
            por_cnt_reg <= 6'(POR_PERIODS);
         end else if (por_reg && tick_edge) begin
            por_cnt_reg <= por_cnt_reg - 6'h01;
            if (por_cnt_reg == 6'h01) begin
               por_reg <= 1'b0;
               nmi_reg <= 1'b1;
            end
         end
      end
   end

   //=====================================
   // Power mode tracking
   plck_mode_t mode_reg, mode_next;
   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         PLCK_RUN: if (wfi_i) mode_next = deep_sleep_en_i ? PLCK_DEEP : PLCK_SLEEP;
         PLCK_SLEEP: if (wake_irq_i) mode_next = PLCK_RUN;
         PLCK_DEEP: if (wake_irq_i) mode_next = PLCK_RUN;
         default: mode_next = PLCK_RUN;
      endcase
   end
   wire deep_entry = mode_reg == PLCK_RUN && mode_next == PLCK_DEEP;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mode_reg <= PLCK_RUN;
         deep_pll_reg <= 1'b0;
      end else if (ce_i) begin
         mode_reg <= mode_next;
         if (deep_entry) deep_pll_reg <= !sel_pwrdn;
         else if (mode_next == PLCK_RUN) deep_pll_reg <= 1'b0;
      end
   end

   //=====================================
   // Clock source, divisor and gates
   wire in_deep = mode_reg == PLCK_DEEP;
   wire ds_int = deepsleep_clock_cfg_i != 2'b00;
   wire [1:0] run_src = (!sel_bypass && pll_usable) ? PLCK_SRC_PLL :
                        (sel_src == 2'b00 ? PLCK_SRC_MAIN : PLCK_SRC_INT);
   wire [1:0] src_sel = fail_reg ? PLCK_SRC_INT :
                        in_deep ? (ds_int ? PLCK_SRC_INT : PLCK_SRC_MAIN) : run_src;
   wire [6:0] div_sel = (in_deep && deep_pll_reg) ?
                        {1'b0, deepsleep_div_override_i} + 7'h01 : run_div;
   wire gate_sel_sleep = mode_reg == PLCK_SLEEP && auto_gate_i;
   wire gate_sel_deep = in_deep && auto_gate_i;
   wire [NPER-1:0] gate_next = gate_sel_deep ? deepsleep_gating_regs_i :
                               gate_sel_sleep ? sleep_gating_regs_i : run_gating_regs_i;
   wire [NPER-1:0] gate_fin = (in_deep && mode_next == PLCK_RUN) ? periph_clk_en_o : gate_next;

   logic [1:0] src_reg;
   logic [6:0] div_reg;
   logic [NPER-1:0] gate_reg;
   logic core_reg, pll_en_reg, main_osc_reg, internal_osc_reg;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         src_reg <= PLCK_SRC_INT;
         div_reg <= PLCK_DIV_RESET + 7'h01;
         gate_reg <= '0;
         core_reg <= 1'b1;
         pll_en_reg <= 1'b0;
         main_osc_reg <= 1'b0;
         internal_osc_reg <= 1'b1;
      end else if (ce_i) begin
         src_reg <= src_sel;
         div_reg <= div_sel;
         gate_reg <= gate_fin;
         core_reg <= mode_next == PLCK_RUN;
         pll_en_reg <= !pll_pwrdn_eff && !fail_reg;
         main_osc_reg <= !fail_reg && !(in_deep && ds_int);
         internal_osc_reg <= fail_reg || int_osc_dis_i == 1'b0 || (in_deep && ds_int);
      end
   end

   assign pll_translation_reg_o = xlate_reg;
   assign pll_lock_raw_flag_o = flag_reg;
   assign pll_lock_irq_o = irq_reg;
   assign pll_enable_o = pll_en_reg;
   assign sysclk_src_o = src_reg;
   assign sysclk_div_o = div_reg;
   assign main_osc_en_o = main_osc_reg;
   assign int_osc_en_o = internal_osc_reg;
   assign osc_fail_cause_o = fail_reg;
   assign int_por_o = por_reg;
   assign nmi_o = nmi_reg;
   assign core_clk_en_o = core_reg;
   assign periph_clk_en_o = gate_reg;

   //=====================================
   // Checks
   no_pll_busy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      lock_busy |=> src_reg != PLCK_SRC_PLL)
      else $error("PLL used during relock");
   flag_clr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && relock_start && !lock_done |=> !flag_reg)
      else $error("flag not cleared");
   flag_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && lock_done |=> flag_reg)
      else $error("flag not set");
   fail_src_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && fail_reg |=> src_reg == PLCK_SRC_INT)
      else $error("no switch to internal osc");
   core_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && mode_next != PLCK_RUN |=> !core_reg)
      else $error("core clock not stopped");
   div_plus_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && !in_deep |=> div_reg == $past(run_div))
      else $error("divisor wrong");
   same_crystal_select_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && crystal_wr_i && crystal_select_i == crystal_select_reg && !powerup && !lock_busy |=> !lock_busy)
      else $error("spurious relock");
   sleep_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && gate_sel_sleep && mode_next == PLCK_SLEEP |=> gate_reg == $past(sleep_gating_regs_i))
      else $error("sleep gating wrong");
   powerup_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && powerup |=> lock_busy)
      else $error("no relock on power-up");
   xlate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && crystal_wr_i |=> xlate_reg == xlate($past(crystal_select_i)))
      else $error("translation not updated");
   irq_mask_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && !pll_lock_mask_i |=> !irq_reg)
      else $error("masked lock irq raised");
   pll_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && pll_pwrdn_eff |=> !pll_en_reg)
      else $error("PLL driven in power-down");
   src_pll_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && !sel_bypass && pll_usable && !fail_reg && !in_deep |=> src_reg == PLCK_SRC_PLL)
      else $error("no switch to PLL after lock");

   //=====================================
   // Failure, mode and gate checks
   fail_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      fail_reg |=> fail_reg)
      else $error("failure cause lost");
   fail_osc_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && fail_reg |=> internal_osc_reg && !main_osc_reg && !pll_en_reg)
      else $error("oscillators wrong after failure");
   por_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && por_reg && tick_edge && por_cnt_reg == 6'h01 |=> nmi_reg && !por_reg)
      else $error("internal reset did not end");
   nmi_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && nmi_reg |=> !nmi_reg)
      else $error("nmi longer than one cycle");
   run_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && mode_reg == PLCK_RUN |=> gate_reg == $past(run_gating_regs_i))
      else $error("run gating wrong");
   deep_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && gate_sel_deep && mode_next == PLCK_DEEP |=> gate_reg == $past(deepsleep_gating_regs_i))
      else $error("deep-sleep gating wrong");
   ds_src_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && in_deep && !fail_reg |=> src_reg == ($past(ds_int) ? PLCK_SRC_INT : PLCK_SRC_MAIN))
      else $error("deep-sleep source wrong");
   ds_pll_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && deep_pll_reg |=> !pll_en_reg)
      else $error("PLL running in deep-sleep");
   deep_div_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && in_deep && deep_pll_reg |=> div_reg == {1'b0, $past(deepsleep_div_override_i)} + 7'h01)
      else $error("deep-sleep divisor wrong");
   exit_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && in_deep && mode_next == PLCK_RUN |=> $stable(gate_reg))
      else $error("gates changed before restore");
   freeze_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ce_i |=> $stable(src_reg) && $stable(gate_reg) && $stable(mode_reg) && $stable(flag_reg))
      else $error("state moved with clock enable low");
endmodule

// ---- sim/plck_osc_model.sv ----
// Oscillator and monitor model for the clock control bench
module plck_osc_model (
   input wire logic clk_i,
   input wire logic fail_i,
   output logic int_osc_tick_o,
   output logic main_osc_bad_o
);
   timeunit 1ns;
   timeprecision 1ns;
   //=====================================
   // Internal oscillator, rising edge every 6 clocks
   logic [1:0] div_reg = 2'h0;
   initial int_osc_tick_o = 1'b0;
   always @(posedge clk_i) begin
      div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
      if (div_reg == 2'h2) int_osc_tick_o <= ~int_osc_tick_o;
   end
   //=====================================
   // Main oscillator stable unless failure injected
   assign main_osc_bad_o = fail_i;
endmodule

// ---- sim/plck_top_tb.sv ----
// Self-checking bench for the clock control block
module plck_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import plck_pkg::*;
   localparam int NP = 32;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, crystal_wr_i = 1'b0, pll_pwrdn_i = 1'b1, bypass_i = 1'b1;
   logic auto_gate_i = 1'b0, ext_config_select_i = 1'b0, ext_pll_pwrdn_i = 1'b1, ext_bypass_i = 1'b1;
   logic osc_check_enable_i = 1'b0, fail = 1'b0, int_osc_dis_i = 1'b0, pll_lock_mask_i = 1'b1, wfi_i = 1'b0;
   logic deep_sleep_en_i = 1'b0, wake_irq_i = 1'b0, main_osc_bad_i, int_osc_tick_i;
   logic [4:0] crystal_select_i = 5'h0B;
   logic [3:0] sysclk_divisor_i = 4'hF;
   logic [1:0] osc_src_i = 2'h0, ext_osc_src_i = 2'h0, deepsleep_clock_cfg_i = 2'h0;
   logic [5:0] ext_sysclk_divisor_i = 6'h0F, deepsleep_div_override_i = 6'h03;
   logic [NP-1:0] run_gating_regs_i = '0, sleep_gating_regs_i = '0, deepsleep_gating_regs_i = '0, periph_clk_en_o;
   logic [13:0] pll_translation_reg_o;
   logic [6:0] sysclk_div_o;
   logic [1:0] sysclk_src_o;
   logic pll_lock_raw_flag_o, pll_lock_irq_o, pll_enable_o, main_osc_en_o, int_osc_en_o;
   logic osc_fail_cause_o, int_por_o, nmi_o, core_clk_en_o;
   int n_errors = 0, check_count = 0;
   //=====================================
   // Design and partner
   plck_top #(.NPER(NP), .POR_PERIODS(4)) dut (
      .clk_i, .sys_rst_i, .ce_i, .crystal_select_i, .crystal_wr_i, .pll_pwrdn_i, .bypass_i, .sysclk_divisor_i,
      .auto_gate_i, .osc_src_i, .ext_config_select_i, .ext_pll_pwrdn_i, .ext_bypass_i, .ext_sysclk_divisor_i,
      .ext_osc_src_i, .osc_check_enable_i, .main_osc_bad_i, .int_osc_tick_i, .int_osc_dis_i, .pll_lock_mask_i,
      .wfi_i, .deep_sleep_en_i, .wake_irq_i, .deepsleep_clock_cfg_i, .deepsleep_div_override_i,
      .run_gating_regs_i, .sleep_gating_regs_i, .deepsleep_gating_regs_i, .pll_translation_reg_o,
      .pll_lock_raw_flag_o, .pll_lock_irq_o, .pll_enable_o, .sysclk_src_o, .sysclk_div_o, .main_osc_en_o,
      .int_osc_en_o, .osc_fail_cause_o, .int_por_o, .nmi_o, .core_clk_en_o, .periph_clk_en_o
   );
   plck_osc_model osc (.clk_i, .fail_i(fail), .int_osc_tick_o(int_osc_tick_i), .main_osc_bad_o(main_osc_bad_i));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   //=====================================
   // Tasks
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   function automatic logic [6:0] exp_div(input logic [5:0] f);
      return {1'b0, f} + 7'h01;
   endfunction
   function automatic logic [13:0] exp_xlate(input logic [4:0] c);
      return {4'h0, 5'(c + 5'h0C), c};
   endfunction
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic relock(input logic by_wr, input logic [4:0] code, input int load);
      int n;
      int early;
      early = 0;
      n = 1;
      if (by_wr) crystal_select_i = code;
      crystal_wr_i = by_wr;
      pll_pwrdn_i = 1'b0;
      tk(1);
      crystal_wr_i = 1'b0;
      tk(1);
      chk("flag clear", pll_lock_raw_flag_o, 1'b0);
      while (pll_lock_raw_flag_o !== 1'b1 && n < 20000) begin
         if (sysclk_src_o === PLCK_SRC_PLL) early++;
         tk(1);
         n++;
      end
      chk("pll before lock", early, 0);
      chk("lock time", n, load + 1);
      if (n >= 20000) final_report();
      tk(1);
      chk("irq", pll_lock_irq_o, pll_lock_mask_i);
      chk("src pll", sysclk_src_o, PLCK_SRC_PLL);
   endtask
   task automatic nap(input logic [NP-1:0] exp_g);
      wfi_i = 1'b1;
      tk(1);
      wfi_i = 1'b0;
      tk(2);
      chk("core off", core_clk_en_o, 1'b0);
      chk("nap gates", periph_clk_en_o, exp_g);
   endtask
   task automatic wake();
      wake_irq_i = 1'b1;
      tk(1);
      wake_irq_i = 1'b0;
      tk(3);
      chk("core on", core_clk_en_o, 1'b1);
      chk("run gates", periph_clk_en_o, run_gating_regs_i);
   endtask
   //=====================================
   // Main sequence
   initial begin
      int r;
      int q;
      r = $urandom(77);
      repeat (11) @(posedge clk_i);
      #1;
      chk("rst src", sysclk_src_o, PLCK_SRC_INT);
      chk("rst div", sysclk_div_o, 7'h10);
      chk("rst pll", pll_enable_o, 1'b0);
      chk("rst flag", pll_lock_raw_flag_o, 1'b0);
      chk("rst xlate", pll_translation_reg_o, exp_xlate(PLCK_CRYSTAL_SELECT_RESET));
      tk(1);
      sys_rst_i = 1'b0;
      fail = 1'b1;
      tk(6);
      chk("no check", osc_fail_cause_o, 1'b0);
      fail = 1'b0;
      for (int i = 0; i < 6; i++) begin
         ext_config_select_i = i[0];
         sysclk_divisor_i = (i == 4) ? 4'h0 : 4'($urandom());
         ext_sysclk_divisor_i = (i == 5) ? 6'h3F : 6'($urandom());
         tk(3);
         chk("div", sysclk_div_o, exp_div(i[0] ? ext_sysclk_divisor_i : {2'b00, sysclk_divisor_i}));
      end
      ext_config_select_i = 1'b0;
      run_gating_regs_i = $urandom();
      sleep_gating_regs_i = $urandom();
      deepsleep_gating_regs_i = $urandom();
      tk(3);
      chk("run gates", periph_clk_en_o, run_gating_regs_i);
      ce_i = 1'b0;
      run_gating_regs_i = ~run_gating_regs_i;
      tk(3);
      chk("frozen gates", periph_clk_en_o, ~run_gating_regs_i);
      ce_i = 1'b1;
      for (int a = 0; a < 4; a++) begin
         auto_gate_i = a[0];
         deep_sleep_en_i = a[1];
         nap(a[0] ? (a[1] ? deepsleep_gating_regs_i : sleep_gating_regs_i) : run_gating_regs_i);
         if (!a[1]) chk("sleep src", sysclk_src_o, PLCK_SRC_MAIN);
         wake();
      end
      bypass_i = 1'b0;
      relock(1'b1, 5'h10, PLCK_LOCK_LONG);
      chk("pll on", pll_enable_o, 1'b1);
      chk("xlate long", pll_translation_reg_o, exp_xlate(5'h10));
      r = pll_translation_reg_o;
      crystal_wr_i = 1'b1;
      tk(1);
      crystal_wr_i = 1'b0;
      tk(3);
      chk("same code", pll_lock_raw_flag_o, 1'b1);
      pll_lock_mask_i = 1'b0;
      tk(2);
      chk("masked", pll_lock_irq_o, 1'b0);
      pll_lock_mask_i = 1'b1;
      relock(1'b1, 5'h0F, PLCK_LOCK_SHORT);
      chk("xlate moved", pll_translation_reg_o !== r[13:0], 1'b1);
      chk("xlate short", pll_translation_reg_o, exp_xlate(5'h0F));
      pll_pwrdn_i = 1'b1;
      tk(3);
      chk("pwrdn", pll_enable_o, 1'b0);
      chk("pwrdn src", sysclk_src_o !== PLCK_SRC_PLL, 1'b1);
      relock(1'b0, 5'h0F, PLCK_LOCK_SHORT);
      deep_sleep_en_i = 1'b1;
      for (int c = 0; c < 2; c++) begin
         deepsleep_clock_cfg_i = c[1:0];
         deepsleep_div_override_i = (c == 0) ? 6'h3F : 6'($urandom());
         nap(deepsleep_gating_regs_i);
         chk("ds div", sysclk_div_o, exp_div(deepsleep_div_override_i));
         chk("ds pll off", pll_enable_o, 1'b0);
         chk("ds src", sysclk_src_o, c ? PLCK_SRC_INT : PLCK_SRC_MAIN);
         chk("ds main", main_osc_en_o, c == 0);
         wake();
         q = 0;
         while (sysclk_src_o !== PLCK_SRC_PLL && q < 20000) begin
            tk(1);
            q++;
         end
         chk("restored src", q < 20000, 1'b1);
         if (q >= 20000) final_report();
         chk("restored div", sysclk_div_o, exp_div({2'b00, sysclk_divisor_i}));
      end
      deep_sleep_en_i = 1'b0;
      int_osc_dis_i = 1'b1;
      osc_check_enable_i = 1'b1;
      tk(2);
      chk("int osc off", int_osc_en_o, 1'b0);
      fail = 1'b1;
      tk(5);
      fail = 1'b0;
      chk("cause", osc_fail_cause_o, 1'b1);
      chk("int osc on", int_osc_en_o, 1'b1);
      chk("fail src", sysclk_src_o, PLCK_SRC_INT);
      chk("por", int_por_o, 1'b1);
      r = 0;
      q = 0;
      while (int_por_o === 1'b1 && r < 200) begin
         tk(1);
         r++;
      end
      chk("por span", r >= 10 && r <= 30, 1'b1);
      if (r >= 200) final_report();
      repeat (6) begin
         if (nmi_o === 1'b1) q++;
         tk(1);
      end
      chk("nmi pulse", q, 1);
      final_report();
   end
   initial begin
      repeat (100000) @(posedge clk_i);
      n_errors++;
      final_report();
   end
endmodule
